/* adc_seq_pkg.sv */
package adc_seq_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] INPUT_SELECT_ADDR = 8'hbb;
    localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
    localparam int NEG_SEL_LSB = 4;
    localparam int POS_SEL_LSB = 0;
    localparam int SEL_WIDTH = 4;
    localparam logic [3:0] NEG_GROUND_BIT = 4'h8;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // ****************************************
    // Start source codes
    // ****************************************
    localparam logic [2:0] SRC_SOFTWARE = 3'h0;
    localparam logic [2:0] SRC_TIMER0 = 3'h1;
    localparam logic [2:0] SRC_TIMER2 = 3'h2;
    localparam logic [2:0] SRC_TIMER1 = 3'h3;
    localparam logic [2:0] SRC_EXTERNAL = 3'h4;
    // ****************************************
    // Timing and widths
    // ****************************************
    localparam int RESULT_BITS = 8;
    localparam int DIVISOR_BITS = 5;
    localparam logic [1:0] TRACK_CLOCKS = 2'h3;
    localparam logic [2:0] FIRST_BIT = 3'h7;
    localparam logic [7:0] FIRST_TRIAL = 8'h80;
    localparam logic [7:0] SIGN_FLIP = 8'h80;

    typedef struct packed {
        logic t0_ovf;
        logic t1_ovf;
        logic t2_low_ovf;
        logic t2_high_ovf;
        logic t2_split8;
    } timer_events_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_TRACK = 3'b010,
        ST_CONV = 3'b100
    } seq_state_type;
endpackage

/* adc_conversion_sequencer.sv */
`timescale 1ns/1ps
// Functional notes
// - SAR clock is system clock divided by divisor plus one, divisor 0 to 31.
// - Three-bit start source field picks one of five conversion triggers.
// - Software source: writing one to busy starts a conversion.
// - Timer 0, 1 or 2 overflow starts a conversion when selected.
// - External source: rising edge on the start pin starts a conversion.
// - Busy stays high during conversion and clears when it finishes.
// - Busy falling at the end of a conversion sets the done flag and raises the interrupt if enabled.
// - New result is readable no later than the done flag rising.
// - Timer 2 trigger uses low-byte overflow in 8-bit mode, high-byte in 16-bit.
// - Normal mode tracks continuously except during a conversion.
// - Low-power mode with a non-external source tracks three SAR clocks after each start, then converts.
// - Low-power external mode tracks while pin low, converts on rising edge.
// - Tracking is shut down during standby or sleep.
// - Input select register, eight bits read-write at 0xbb, reset zero.
// - Ground negative input means single-ended, anything else differential.
// - Results unsigned in single-ended mode, two's complement in differential.
// - Converter works only while enabled, otherwise held shut down.
module adc_conversion_sequencer #(
    parameter int DIVISOR_W = adc_seq_pkg::DIVISOR_BITS,
    parameter int RESULT_W = adc_seq_pkg::RESULT_BITS
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    input wire logic adc_enable_i,
    input wire logic [2:0] start_source_select_i,
    input wire logic low_power_track_mode_i,
    input wire logic [DIVISOR_W-1:0] conv_clock_divisor_i,
    input wire logic busy_write_one_i,
    input wire logic done_clear_i,
    input wire logic irq_enable_i,
    input wire logic standby_i,
    input wire adc_seq_pkg::timer_events_type timers_i,
    input wire logic ext_convert_start_i,
    input wire logic comp_i,
    output logic [RESULT_W-1:0] dac_code_o,
    output logic track_o,
    output logic single_ended_o,
    output logic [3:0] pos_input_select_o,
    output logic [3:0] neg_input_select_o,
    output logic conversion_busy_o,
    output logic conversion_done_flag_o,
    output logic adc_irq_o,
    output logic [RESULT_W-1:0] adc_result_o
);
    if (DIVISOR_W != adc_seq_pkg::DIVISOR_BITS || RESULT_W != adc_seq_pkg::RESULT_BITS) begin : gen_width_check
        $error("Unsupported width parameters");
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [7:0] bit_mask(input logic [2:0] idx);
        bit_mask = 8'h01 << idx;
    endfunction

    function automatic logic pick_trigger(input logic [2:0] src, input logic sw,
                                          input adc_seq_pkg::timer_events_type t, input logic ext_rise);
        case (src)
            adc_seq_pkg::SRC_SOFTWARE: pick_trigger = sw;
            adc_seq_pkg::SRC_TIMER0: pick_trigger = t.t0_ovf;
            adc_seq_pkg::SRC_TIMER1: pick_trigger = t.t1_ovf;
            adc_seq_pkg::SRC_TIMER2: pick_trigger = t.t2_split8 ? t.t2_low_ovf : t.t2_high_ovf;
            adc_seq_pkg::SRC_EXTERNAL: pick_trigger = ext_rise;
            default: pick_trigger = 1'b0;
        endcase
    endfunction

    // ****************************************
    // External start pin synchroniser
    // ****************************************
    logic ext_ff1, ext_ff2, ext_ff3, ext_level;
    logic next_ext_level;
    always_comb begin
        next_ext_level = (ext_ff2 == ext_ff3) ? ext_ff3 : ext_level;
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ext_ff1 <= 1'b0;
            ext_ff2 <= 1'b0;
            ext_ff3 <= 1'b0;
            ext_level <= 1'b0;
        end else if (ce_i) begin
            ext_ff1 <= ext_convert_start_i;
            ext_ff2 <= ext_ff1;
            ext_ff3 <= ext_ff2;
            ext_level <= next_ext_level;
        end
    end
    logic ext_rise;
    assign ext_rise = next_ext_level & ~ext_level;

    // ****************************************
    // Input select register
    // ****************************************
    logic [7:0] input_sel, next_input_sel;
    logic [7:0] rdata, next_rdata;
    always_comb begin
        next_input_sel = input_sel;
        next_rdata = rdata;
        if (sfr_wr_i && sfr_addr_i == adc_seq_pkg::INPUT_SELECT_ADDR) begin
            next_input_sel = sfr_wdata_i;
        end
        if (sfr_rd_i) begin
            next_rdata = (sfr_addr_i == adc_seq_pkg::INPUT_SELECT_ADDR) ? input_sel : adc_seq_pkg::READ_UNMAPPED;
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            input_sel <= adc_seq_pkg::INPUT_SELECT_RESET;
            rdata <= adc_seq_pkg::READ_UNMAPPED;
        end else if (ce_i) begin
            input_sel <= next_input_sel;
            rdata <= next_rdata;
        end
    end
    assign sfr_rdata_o = rdata;
    assign pos_input_select_o = input_sel[adc_seq_pkg::POS_SEL_LSB +: adc_seq_pkg::SEL_WIDTH];
    assign neg_input_select_o = input_sel[adc_seq_pkg::NEG_SEL_LSB +: adc_seq_pkg::SEL_WIDTH];
    assign single_ended_o = (neg_input_select_o & adc_seq_pkg::NEG_GROUND_BIT) != 4'h0;

    // ****************************************
    // Sequencer
    // ****************************************
    adc_seq_pkg::seq_state_type state, next_state;
    logic [DIVISOR_W-1:0] div_cnt, next_div_cnt;
    logic [1:0] trk_cnt, next_trk_cnt;
    logic [2:0] bit_idx, next_bit_idx;
    logic [7:0] sar, next_sar;
    logic [7:0] result, next_result;
    logic done, next_done;
    logic tick, busy, start, finish, ext_src, lp_ext;
    logic [7:0] kept;

    assign tick = (div_cnt == conv_clock_divisor_i);
    assign busy = (state != adc_seq_pkg::ST_IDLE);
    assign ext_src = (start_source_select_i == adc_seq_pkg::SRC_EXTERNAL);
    assign lp_ext = low_power_track_mode_i & ext_src;
    assign start = adc_enable_i & ~busy
                 & pick_trigger(start_source_select_i, busy_write_one_i, timers_i, ext_rise);
    assign finish = (state == adc_seq_pkg::ST_CONV) && tick && bit_idx == 3'h0;
    assign kept = comp_i ? sar : (sar & ~bit_mask(bit_idx));

    always_comb begin
        next_state = state;
        next_div_cnt = tick ? '0 : DIVISOR_W'(div_cnt + 1'b1);
        next_trk_cnt = trk_cnt;
        next_bit_idx = bit_idx;
        next_sar = sar;
        next_result = result;
        next_done = done & ~done_clear_i;
        case (state)
            adc_seq_pkg::ST_IDLE: begin
                if (start) begin
                    next_div_cnt = '0;
                    next_trk_cnt = 2'h0;
                    next_bit_idx = adc_seq_pkg::FIRST_BIT;
                    next_sar = adc_seq_pkg::FIRST_TRIAL;
                    if (low_power_track_mode_i && !lp_ext) begin
                        next_state = adc_seq_pkg::ST_TRACK;
                    end else begin
                        next_state = adc_seq_pkg::ST_CONV;
                    end
                end
            end
            adc_seq_pkg::ST_TRACK: begin
                if (tick) begin
                    next_trk_cnt = 2'(trk_cnt + 1'b1);
                    if (2'(trk_cnt + 1'b1) == adc_seq_pkg::TRACK_CLOCKS) begin
                        next_state = adc_seq_pkg::ST_CONV;
                    end
                end
            end
            adc_seq_pkg::ST_CONV: begin
                if (tick) begin
                    if (bit_idx == 3'h0) begin
                        next_result = single_ended_o ? kept : (kept ^ adc_seq_pkg::SIGN_FLIP);
                        next_done = 1'b1;
                        next_state = adc_seq_pkg::ST_IDLE;
                    end else begin
                        next_sar = kept | bit_mask(3'(bit_idx - 1'b1));
                        next_bit_idx = 3'(bit_idx - 1'b1);
                    end
                end
            end
            default: next_state = adc_seq_pkg::ST_IDLE;
        endcase
        if (!adc_enable_i) begin
            next_state = adc_seq_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            state <= adc_seq_pkg::ST_IDLE;
            div_cnt <= '0;
            trk_cnt <= 2'h0;
            bit_idx <= 3'h0;
            sar <= 8'h00;
            result <= 8'h00;
            done <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            div_cnt <= next_div_cnt;
            trk_cnt <= next_trk_cnt;
            bit_idx <= next_bit_idx;
            sar <= next_sar;
            result <= next_result;
            done <= next_done;
        end
    end

    assign dac_code_o = sar;
    assign adc_result_o = result;
    assign conversion_busy_o = busy;
    assign conversion_done_flag_o = done;
    assign adc_irq_o = done & irq_enable_i;
    always_comb begin
        if (!adc_enable_i || standby_i) begin
            track_o = 1'b0;
        end else if (!low_power_track_mode_i) begin
            track_o = !busy;
        end else if (lp_ext) begin
            track_o = !busy && !ext_level;
        end else begin
            track_o = (state == adc_seq_pkg::ST_TRACK);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    sequence seq_finish;
        ce_i && finish;
    endsequence
    sequence seq_lp_start;
        ce_i && start && low_power_track_mode_i && !lp_ext;
    endsequence

    busy_fall_done_a: assert property (seq_finish |=> !busy && done) else $error("Done not set at busy fall");
    irq_gate_a: assert property ($rose(done) |-> $past(busy) && !busy && adc_irq_o == irq_enable_i)
        else $error("Interrupt gating wrong");
    result_ready_a: assert property ($rose(done) |-> $past(finish)
        && result[7:1] == ($past(sar[7:1]) ^ ($past(single_ended_o) ? 7'h00 : adc_seq_pkg::SIGN_FLIP[7:1])))
        else $error("Result late");
    hold_busy_a: assert property (ce_i && busy && !finish && adc_enable_i |=> busy) else $error("Busy dropped");
    sw_start_a: assert property (ce_i && adc_enable_i && !busy
        && start_source_select_i == adc_seq_pkg::SRC_SOFTWARE && busy_write_one_i |=> busy)
        else $error("Software start lost");
    lp_track_a: assert property (seq_lp_start |=> state == adc_seq_pkg::ST_TRACK [*3]) else $error("Short track");
    track_cont_a: assert property (adc_enable_i && !standby_i && !low_power_track_mode_i && !busy |-> track_o)
        else $error("Not tracking");
    disabled_idle_a: assert property (ce_i && !adc_enable_i |=> !busy) else $error("Active while disabled");
    tick_space_a: assert property (ce_i && tick && conv_clock_divisor_i != '0 && $stable(conv_clock_divisor_i)
        |=> !tick || !ce_i) else $error("Divider too fast");
    sel_write_a: assert property (ce_i && sfr_wr_i && sfr_addr_i == adc_seq_pkg::INPUT_SELECT_ADDR
        |=> input_sel == $past(sfr_wdata_i)) else $error("Select write lost");
endmodule

/* far_side_model.sv */
`timescale 1ns/1ps
// ****************************************
// Comparator seen by the SAR logic
// ****************************************
module far_side_model (
    input wire logic [7:0] level_i,
    input wire logic [7:0] dac_code_i,
    output logic comp_o
);
    // High while the held input is at or above the trial code
    assign comp_o = (level_i >= dac_code_i);
endmodule

/* tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0, rd = 1'b0, en = 1'b0, lp = 1'b0, bw = 1'b0, dc = 1'b0;
    logic ie = 1'b0, sb = 1'b0, ext = 1'b0, comp, trk, se, busy, done, irq;
    logic [7:0] addr = 8'h00, wd = 8'h00, level = 8'h00, rdat, dac, res;
    logic [3:0] pos, neg;
    logic [2:0] src = 3'h0;
    logic [4:0] div = 5'h00;
    adc_seq_pkg::timer_events_type tm = '0;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    adc_conversion_sequencer dut (.mclk_i(clk), .rst_i(rst), .ce_i(1'b1), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wd), .sfr_rdata_o(rdat), .adc_enable_i(en),
        .start_source_select_i(src), .low_power_track_mode_i(lp), .conv_clock_divisor_i(div),
        .busy_write_one_i(bw), .done_clear_i(dc), .irq_enable_i(ie), .standby_i(sb), .timers_i(tm),
        .ext_convert_start_i(ext), .comp_i(comp), .dac_code_o(dac), .track_o(trk),
        .single_ended_o(se), .pos_input_select_o(pos), .neg_input_select_o(neg),
        .conversion_busy_o(busy), .conversion_done_flag_o(done), .adc_irq_o(irq), .adc_result_o(res));
    far_side_model far (.level_i(level), .dac_code_i(dac), .comp_o(comp));
    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            complete_run();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {addr, wd, wr} = {a, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        `CHK("rdata", e, rdat)
    endtask
    task automatic fire(input int k);
        @(negedge clk);
        case (k)
            0: bw = 1'b1;
            1: tm.t0_ovf = 1'b1;
            2: tm.t1_ovf = 1'b1;
            3: tm.t2_low_ovf = 1'b1;
            4: tm.t2_high_ovf = 1'b1;
            default: ext = 1'b1;
        endcase
        @(negedge clk);
        bw = 1'b0;
        tm = {4'h0, tm.t2_split8};
    endtask
    task automatic quiet(input int k);
        fire(k);
        repeat (5) @(negedge clk);
        `CHK("no start", 1'b0, busy)
    endtask
    task automatic conv(input int k, input int len, input logic [7:0] e, input logic et);
        int n;
        n = 0;
        fire(k);
        while (busy !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        `CHK("start", 1'b1, busy)
        `CHK("track", et, trk)
        n = 0;
        while (busy === 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
            bw = (n == 3);
        end
        `CHK("busy len", len, n)
        `CHK("done", 1'b1, done)
        `CHK("result", e, res)
        `CHK("irq", ie, irq)
        {ext, dc} = 2'b01;
        @(negedge clk);
        dc = 1'b0;
        `CHK("cleared", 1'b0, done)
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        sfr_rd(8'hbb, 8'h00);
        sfr_wr(8'hbb, 8'h85);
        `CHK("pos neg se", {4'h5, 4'h8, 1'b1}, {pos, neg, se})
        sfr_wr(8'hba, 8'h11);
        sfr_rd(8'hbb, 8'h85);
        sfr_rd(8'hba, 8'h00);
        {en, ie, level} = {2'b11, 8'h5a};
        @(negedge clk);
        `CHK("idle track", 1'b1, trk)
        conv(0, 8, 8'h5a, 1'b0);
        ie = 1'b0;
        for (int k = 1; k < 5; k++) begin
            src = (k == 1) ? adc_seq_pkg::SRC_TIMER0 : (k == 2) ? adc_seq_pkg::SRC_TIMER1
                : adc_seq_pkg::SRC_TIMER2;
            tm.t2_split8 = (k == 3);
            quiet((k == 3) ? 4 : (k == 4) ? 3 : k % 2 + 1);
            conv(k, 8, 8'h5a, 1'b0);
        end
        src = adc_seq_pkg::SRC_EXTERNAL;
        quiet(0);
        conv(5, 8, 8'h5a, 1'b0);
        sfr_wr(8'hbb, 8'h15);
        {src, level} = {adc_seq_pkg::SRC_SOFTWARE, 8'h30};
        `CHK("diff", 1'b0, se)
        conv(0, 8, 8'hb0, 1'b0);
        div = 5'h1f;
        conv(0, 256, 8'hb0, 1'b0);
        {lp, div} = {1'b1, 5'h01};
        conv(0, 22, 8'hb0, 1'b1);
        {src, div} = {adc_seq_pkg::SRC_EXTERNAL, 5'h00};
        @(negedge clk);
        `CHK("pin low track", 1'b1, trk)
        conv(5, 8, 8'hb0, 1'b0);
        {lp, sb} = 2'b01;
        @(negedge clk);
        `CHK("standby", 1'b0, trk)
        {sb, src} = {1'b0, adc_seq_pkg::SRC_SOFTWARE};
        fire(0);
        repeat (3) @(negedge clk);
        en = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("abort", 2'b00, {busy, done})
        complete_run();
    end
endmodule
